// >>> rtl/cca_pkg.sv
package cca_pkg;
   // ---------------------------------------------------------------
   // Counter clock sources
   // ---------------------------------------------------------------
   localparam logic [2:0] SRC_DIV12 = 3'h0;
   localparam logic [2:0] SRC_DIV4 = 3'h1;
   localparam logic [2:0] SRC_T0OVF = 3'h2;
   localparam logic [2:0] SRC_EXT_COUNT = 3'h3;
   localparam logic [2:0] SRC_SYSCLK = 3'h4;
   localparam logic [2:0] SRC_XOSC8 = 3'h5;
   localparam int DIV12 = 12;
   localparam int DIV4 = 4;
   localparam int XOSC_DIV = 8;
   // ---------------------------------------------------------------
   // Module modes
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_CAPTURE = 3'h1;
   localparam logic [2:0] MODE_SWTIMER = 3'h2;
   localparam logic [2:0] MODE_HSOUT = 3'h3;
   localparam logic [2:0] MODE_PWM = 3'h4;
   localparam logic [2:0] MODE_FREQ = 3'h5;
   // ---------------------------------------------------------------
   // Capture edges and PWM widths
   // ---------------------------------------------------------------
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [2:0] PWM_8 = 3'h0;
   localparam logic [2:0] PWM_9 = 3'h1;
   localparam logic [2:0] PWM_10 = 3'h2;
   localparam logic [2:0] PWM_11 = 3'h3;
   localparam logic [2:0] PWM_16 = 3'h4;
   // ---------------------------------------------------------------
   // Sizes and reset values
   // ---------------------------------------------------------------
   localparam int NUM_MOD = 3;
   localparam int WD_MOD = 2;
   localparam logic [15:0] WD_RELOAD_RST = 16'hffff;
endpackage : cca_pkg

// >>> rtl/cca_top.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - One shared 16-bit time base serves three capture/compare modules.
// - Counter clock picks one of six sources: div12, div4, t0, ext, sys, xosc/8.
// - Each module does capture, software timer, fast output, PWM or frequency output.
// - PWM resolution selectable as 8, 9, 10, 11 or 16 bits.
// - Module 2 can also act as a watchdog.
// - After reset module 2 is in watchdog mode and enabled.
// - Module outputs and external count input are offered to the crossbar.
// - Counting stalls while the core is halted by debug.
module cca_top
   import cca_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Control from the core
   input wire logic [2:0] i_clk_src,
   input wire logic i_run,
   input wire logic i_debug_halt,
   input wire logic i_t0_overflow,
   input wire logic [3*NUM_MOD-1:0] i_mode,
   input wire logic [2*NUM_MOD-1:0] i_cap_edge,
   input wire logic [3*NUM_MOD-1:0] i_pwm_width,
   input wire logic [16*NUM_MOD-1:0] i_compare,
   input wire logic i_wd_disable,
   input wire logic i_wd_kick,
   // Pins through the crossbar
   input wire logic i_ext_count,
   input wire logic i_xosc,
   input wire logic [NUM_MOD-1:0] i_cap_pin,
   // Outputs
   output logic [NUM_MOD-1:0] o_mod_out,
   output logic [NUM_MOD-1:0] o_match,
   output logic [16*NUM_MOD-1:0] o_capture,
   output logic [15:0] o_count,
   output logic o_wd_enabled,
   output logic o_wd_reset
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [NUM_MOD+1:0] sync1;
   logic [NUM_MOD+1:0] sync2;
   logic [NUM_MOD+1:0] sync_old;
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync_old <= '0;
      end else begin
         sync1 <= {i_xosc, i_ext_count, i_cap_pin};
         sync2 <= sync1;
         sync_old <= sync2;
      end
   end
   logic [NUM_MOD+1:0] rise;
   logic [NUM_MOD+1:0] fall;
   assign rise = sync2 & ~sync_old;
   assign fall = ~sync2 & sync_old;

   // ---------------------------------------------------------------
   // Prescalers
   // ---------------------------------------------------------------
   logic [3:0] div_cnt12;
   logic [1:0] div_cnt4;
   logic [2:0] xosc_cnt;
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         div_cnt12 <= '0;
         div_cnt4 <= '0;
         xosc_cnt <= '0;
      end else begin
         div_cnt12 <= (div_cnt12 == 4'(DIV12 - 1)) ? 4'h0 : div_cnt12 + 4'h1;
         div_cnt4 <= div_cnt4 + 2'h1;
         if (rise[NUM_MOD+1]) begin
            xosc_cnt <= xosc_cnt + 3'h1;
         end
      end
   end

   logic tick;
   always_comb begin
      case (i_clk_src)
         SRC_DIV12: tick = (div_cnt12 == 4'(DIV12 - 1));
         SRC_DIV4: tick = (div_cnt4 == 2'(DIV4 - 1));
         SRC_T0OVF: tick = i_t0_overflow;
         SRC_EXT_COUNT: tick = rise[NUM_MOD];
         SRC_SYSCLK: tick = 1'b1;
         SRC_XOSC8: tick = rise[NUM_MOD+1] && (xosc_cnt == 3'(XOSC_DIV - 1));
         default: tick = 1'b0;
      endcase
   end
   logic step;
   assign step = tick && i_run && !i_debug_halt;

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   logic [15:0] count;
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         count <= '0;
      end else if (step) begin
         count <= count + 16'h1;
      end
   end
   assign o_count = count;

   function automatic logic [15:0] pwm_mask(input logic [2:0] w);
      case (w)
         PWM_8: pwm_mask = 16'h00ff;
         PWM_9: pwm_mask = 16'h01ff;
         PWM_10: pwm_mask = 16'h03ff;
         PWM_11: pwm_mask = 16'h07ff;
         default: pwm_mask = 16'hffff;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Capture/compare modules
   // ---------------------------------------------------------------
   logic [NUM_MOD-1:0] freq_arm;
   logic [15:0] freq_next [NUM_MOD];
   for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
      logic [2:0] mode;
      logic [15:0] cmp;
      logic [15:0] msk;
      logic hit;
      assign mode = i_mode[3*m +: 3];
      assign cmp = i_compare[16*m +: 16];
      assign msk = pwm_mask(i_pwm_width[3*m +: 3]);
      assign hit = step && ((count + 16'h1) == cmp);
      always_ff @(posedge i_sys_clk) begin
         if (!i_nrst) begin
            o_mod_out[m] <= 1'b0;
            o_match[m] <= 1'b0;
            o_capture[16*m +: 16] <= '0;
            freq_next[m] <= '0;
            freq_arm[m] <= 1'b0;
         end else begin
            o_match[m] <= 1'b0;
            case (mode)
               MODE_CAPTURE: begin
                  if ((i_cap_edge[2*m] && rise[m]) || (i_cap_edge[2*m+1] && fall[m])) begin
                     o_capture[16*m +: 16] <= count;
                     o_match[m] <= 1'b1;
                  end
               end
               MODE_SWTIMER: o_match[m] <= hit;
               MODE_HSOUT: begin
                  o_match[m] <= hit;
                  if (hit) begin
                     o_mod_out[m] <= ~o_mod_out[m];
                  end
               end
               MODE_PWM: o_mod_out[m] <= ((count & msk) >= (cmp & msk));
               MODE_FREQ: begin
                  if (!freq_arm[m]) begin
                     freq_next[m] <= count + {8'h00, cmp[7:0]};
                     freq_arm[m] <= 1'b1;
                  end else if (step && (count + 16'h1) == freq_next[m]) begin
                     o_mod_out[m] <= ~o_mod_out[m];
                     freq_next[m] <= freq_next[m] + {8'h00, cmp[7:0]};
                  end
               end
               default: o_mod_out[m] <= 1'b0;
            endcase
            if (mode != MODE_FREQ) begin
               freq_arm[m] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Watchdog on module 2
   // ---------------------------------------------------------------
   logic [15:0] wd_limit;
   logic wd_hit;
   assign wd_hit = o_wd_enabled && step && ((count + 16'h1) == wd_limit);
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_wd_enabled <= 1'b1;
         o_wd_reset <= 1'b0;
         wd_limit <= WD_RELOAD_RST;
      end else begin
         o_wd_reset <= wd_hit;
         if (i_wd_disable) begin
            o_wd_enabled <= 1'b0;
         end
         if (i_wd_kick) begin
            wd_limit <= count + i_compare[16*WD_MOD +: 16];
         end
      end
   end
   // crossbar signals are o_mod_out and the raw i_ext_count pin, synchronised only inside this block.

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // wrap
   a_count_step: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      step |=> count == $past(count) + 16'h1) else $error("count did not step");
   a_debug_stall: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_debug_halt |=> count == $past(count)) else $error("count moved in halt");
   a_count_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      !step |=> $stable(count)) else $error("count moved without event");
   a_sysclk_src: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_src == SRC_SYSCLK && i_run && !i_debug_halt) |-> step)
      else $error("sysclk source missed");
   // divide by four
   // Software may change the source right after a step, so only divide-by-four ticks count.
   a_div4_src: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_src == SRC_DIV4 && step) |=> (i_clk_src != SRC_DIV4 || !tick)[*3])
      else $error("div4 too fast");
   a_wd_reset_on: assert property (@(posedge i_sys_clk)
      !i_nrst |=> o_wd_enabled) else $error("watchdog off after reset");
   a_wd_fire: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      wd_hit |=> o_wd_reset) else $error("watchdog did not fire");
   a_capture_val: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_mode[2:0] == MODE_CAPTURE &&
      ((i_cap_edge[0] && rise[0]) || (i_cap_edge[1] && fall[0])))
      |=> o_capture[15:0] == $past(count)) else $error("capture wrong");
   a_pwm8_out: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_mode[2:0] == MODE_PWM && i_pwm_width[2:0] == PWM_8)
      |=> o_mod_out[0] == ($past(count[7:0]) >= $past(i_compare[7:0])))
      else $error("pwm8 wrong");
   c_wrap: cover property (@(posedge i_sys_clk) step && count == 16'hffff);
   c_wd_fire: cover property (@(posedge i_sys_clk) o_wd_reset);
   c_capture: cover property (@(posedge i_sys_clk) o_match[0] && i_mode[2:0] == MODE_CAPTURE);
   c_halt: cover property (@(posedge i_sys_clk) tick && i_debug_halt);
endmodule // cca_top
`default_nettype wire

// >>> tb/cca_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module cca_pin_model (
   // Clock
   input wire logic i_sys_clk,
   // Pins toward the block
   output logic o_ext_count,
   output logic o_xosc,
   output logic [2:0] o_cap_pin
);
   initial begin
      o_ext_count = 1'b0;
      o_xosc = 1'b0;
      o_cap_pin = 3'h0;
   end
   // Whole periods only, so both clock pins stand still between bursts.
   task automatic pulse(input int which, input int n);
      repeat (2 * n) begin
         repeat (4) @(posedge i_sys_clk);
         if (which == 0) o_ext_count <= ~o_ext_count;
         else o_xosc <= ~o_xosc;
      end
   endtask
   task automatic cap_set(input int m, input logic v);
      @(posedge i_sys_clk);
      o_cap_pin[m] <= v;
   endtask
endmodule // cca_pin_model
`default_nettype wire

// >>> tb/counter_array_capture_compare_tb.sv
`timescale 1ns/10ps
`default_nettype none
module counter_array_capture_compare_tb
   import cca_pkg::*;
;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [2:0] i_clk_src = SRC_T0OVF;
   logic i_run = 1'b1;
   logic i_debug_halt = 1'b0;
   logic i_t0_overflow = 1'b0;
   logic [3*NUM_MOD-1:0] i_mode = '0;
   logic [2*NUM_MOD-1:0] i_cap_edge = '0;
   logic [3*NUM_MOD-1:0] i_pwm_width = '0;
   logic [16*NUM_MOD-1:0] i_compare = '0;
   logic i_wd_disable = 1'b0;
   logic i_wd_kick = 1'b0;
   logic i_ext_count, i_xosc, o_wd_enabled, o_wd_reset, seen;
   logic [NUM_MOD-1:0] i_cap_pin, o_mod_out, o_match, prev;
   logic [16*NUM_MOD-1:0] o_capture;
   logic [15:0] o_count;
   int error_cnt = 0;
   int checked = 0;
   int mc = 0;
   int unsigned rs = 65;
   int cmpv [NUM_MOD];
   int tog [NUM_MOD];
   cca_top u_cca_top (
      .i_sys_clk, .i_nrst, .i_clk_src, .i_run, .i_debug_halt, .i_t0_overflow,
      .i_mode, .i_cap_edge, .i_pwm_width, .i_compare, .i_wd_disable, .i_wd_kick,
      .i_ext_count, .i_xosc, .i_cap_pin,
      .o_mod_out, .o_match, .o_capture, .o_count, .o_wd_enabled, .o_wd_reset
   );
   cca_pin_model u_cca_pin_model (
      .i_sys_clk, .o_ext_count(i_ext_count), .o_xosc(i_xosc), .o_cap_pin(i_cap_pin)
   );
   always #5 i_sys_clk = ~i_sys_clk;
   // ----------------------------
   // Model and helpers
   // ----------------------------
   function automatic int unsigned rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic pwm_exp(input int w, input int c);
      int mask;
      mask = (w == 4) ? 65535 : (1 << (8 + w)) - 1;
      return (mc & mask) >= (c & mask);
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk16({15'h0, got}, {15'h0, exp}, what);
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   // Timer 0 held high steps the time base once per cycle.
   task automatic step(input int n);
      @(posedge i_sys_clk);
      i_t0_overflow <= 1'b1;
      repeat (n) @(posedge i_sys_clk);
      i_t0_overflow <= 1'b0;
      #1;
      if (i_debug_halt !== 1'b1 && i_run === 1'b1) mc = (mc + n) % 65536;
   endtask
   task automatic do_reset();
      @(posedge i_sys_clk);
      i_nrst <= 1'b0;
      repeat (20) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      #1;
      mc = 0;
   endtask
   task automatic wait_match(input int m);
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         clk(1);
         seen = (o_match[m] === 1'b1);
      end
   endtask
   task automatic rate(input logic [2:0] src, input int n, input int d);
      logic [15:0] c0;
      @(posedge i_sys_clk);
      i_clk_src <= src;
      clk(30);
      c0 = o_count;
      if (src == SRC_EXT_COUNT || src == SRC_XOSC8) begin
         u_cca_pin_model.pulse(src == SRC_XOSC8, n);
         clk(8);
      end else begin
         clk(n);
      end
      chk16(o_count - c0, 16'(n / d), "rate");
      $display("rate done");
   endtask
   initial begin
      repeat (90000) @(posedge i_sys_clk);
      $display("BAD %0t run too long", $time);
      error_cnt++;
      close_out();
   end
   // ----------------------------
   // Scenarios
   // ----------------------------
   initial begin
      do_reset();
      chk1(o_wd_enabled, 1'b1, "wd on");
      chk16(o_count, 16'h0, "count");
      step(65535);
      chk16(o_count, 16'hffff, "top");
      chk1(o_wd_reset, 1'b1, "wd expiry at reset limit");
      step(1);
      chk16(o_count, 16'h0, "wrap");
      i_debug_halt <= 1'b1;
      step(7);
      chk16(o_count, 16'(mc), "halt");
      i_debug_halt <= 1'b0;
      step(3);
      chk16(o_count, 16'(mc), "resume");
      i_run <= 1'b0;
      step(4);
      chk16(o_count, 16'(mc), "stopped");
      i_run <= 1'b1;
      @(posedge i_sys_clk);
      for (int m = 0; m < NUM_MOD; m++) begin
         i_mode[3*m +: 3] <= MODE_SWTIMER;
         i_compare[16*m +: 16] <= 16'(mc + 2 + m);
      end
      for (int k = 1; k <= 4; k++) begin
         step(1);
         for (int m = 0; m < NUM_MOD; m++) chk1(o_match[m], 1'(k == 2 + m), "sw");
      end
      $display("base done");
      for (int m = 0; m < NUM_MOD; m++) begin
         step(1 + rnd() % 40);
         i_mode[3*m +: 3] <= MODE_CAPTURE;
         i_cap_edge[2*m +: 2] <= EDGE_FALL;
         u_cca_pin_model.cap_set(m, 1'b1);
         wait_match(m);
         chk1(seen, 1'b0, "rise ignored");
         u_cca_pin_model.cap_set(m, 1'b0);
         wait_match(m);
         chk1(seen, 1'b1, "capture");
         chk16(o_capture[16*m +: 16], 16'(mc), "cap value");
         i_cap_edge[2*m +: 2] <= EDGE_RISE;
         step(1 + rnd() % 40);
         u_cca_pin_model.cap_set(m, 1'b1);
         wait_match(m);
         chk1(seen, 1'b1, "rise capture");
         chk16(o_capture[16*m +: 16], 16'(mc), "rise value");
         u_cca_pin_model.cap_set(m, 1'b0);
      end
      do_reset();
      i_mode <= {NUM_MOD{MODE_HSOUT}};
      i_compare <= {NUM_MOD{16'h0003}};
      step(2);
      chk16(16'(o_mod_out), 16'h0, "hs before");
      step(1);
      chk16(16'(o_mod_out), 16'h7, "hs set");
      for (int w = 0; w < 5; w++) begin
         i_mode <= {NUM_MOD{MODE_PWM}};
         i_pwm_width <= {NUM_MOD{3'(w)}};
         for (int m = 0; m < NUM_MOD; m++) begin
            cmpv[m] = rnd() % 65536;
            i_compare[16*m +: 16] <= 16'(cmpv[m]);
         end
         step(1 + rnd() % 400);
         clk(2);
         for (int m = 0; m < NUM_MOD; m++) chk1(o_mod_out[m], pwm_exp(w, cmpv[m]), "pwm");
      end
      i_mode <= {NUM_MOD{MODE_FREQ}};
      i_compare <= {16'h0004, 16'h0003, 16'h0002};
      clk(2);
      for (int k = 0; k < 12; k++) begin
         prev = o_mod_out;
         step(1);
         for (int m = 0; m < NUM_MOD; m++) tog[m] += (o_mod_out[m] !== prev[m]);
      end
      for (int m = 0; m < NUM_MOD; m++) chk16(16'(tog[m]), 16'(12 / (2 + m)), "freq");
      $display("modes done");
      do_reset();
      chk1(o_wd_enabled, 1'b1, "wd on again");
      i_mode <= '0;
      i_compare[16*WD_MOD +: 16] <= 16'h000a;
      step(5);
      i_wd_kick <= 1'b1;
      clk(1);
      i_wd_kick <= 1'b0;
      step(9);
      chk1(o_wd_reset, 1'b0, "wd early");
      step(1);
      chk1(o_wd_reset, 1'b1, "wd expiry");
      i_wd_disable <= 1'b1;
      clk(2);
      chk1(o_wd_enabled, 1'b0, "wd off");
      step(12);
      chk1(o_wd_reset, 1'b0, "wd silent");
      $display("wd done");
      rate(SRC_DIV12, 48, DIV12);
      rate(SRC_DIV4, 48, DIV4);
      rate(SRC_SYSCLK, 48, 1);
      rate(SRC_EXT_COUNT, 5, 1);
      rate(SRC_XOSC8, 16, XOSC_DIV);
      close_out();
   end
endmodule // counter_array_capture_compare_tb
`default_nettype wire
